// >>> pkg/mpcs_regs.svh
/*
 * timing and field constants for the multiport MAC client stream block.
 * assumes inclusion by bare name; definitions only.
 */
`ifndef MPCS_REGS_SVH
`define MPCS_REGS_SVH
// ==========================================================================
// clock rates and divider counts (core clock 20 MHz)
`define MPCS_CORE_CLK_KHZ      20000
`define MPCS_LINK_1000_KHZ     125000
`define MPCS_LINK_100_KHZ      25000
`define MPCS_LINK_10_KHZ       2500
// half-period of the 2.5 MHz strobe: 20000/2500/2 = 4 core cycles
`define MPCS_DIV_10_HALF       (`MPCS_CORE_CLK_KHZ / `MPCS_LINK_10_KHZ / 2)
`define MPCS_DIV_W             4
// ==========================================================================
// error vector and data widths, crc constants
`define MPCS_ERR_W             5
`define MPCS_DATA_W            8
`define MPCS_CRC_INIT          32'hFFFF_FFFF
`define MPCS_CRC_POLY          32'hEDB8_8320
`endif

// >>> pkg/mpcs_pkg.sv
/*
 * types shared by the multiport MAC client stream block.
 * assumes mpcs_regs.svh supplies constants.
 */
package mpcs_pkg;
    // ======================================================================
    // link speed select
    typedef enum logic [1:0] {MPCS_SPD_10, MPCS_SPD_100, MPCS_SPD_1000}
        mpcs_speed_t;
    // transmit-side state
    typedef enum logic [1:0] {MPCS_TX_DATA, MPCS_TX_CRC} mpcs_txst_t;
    // receive-side state
    typedef enum logic [1:0] {MPCS_RX_IDLE, MPCS_RX_PASS, MPCS_RX_DROP}
        mpcs_rxst_t;
endpackage

// >>> rtl/mpcs_client.sv
/*
 * per-port client stream of a multiport MAC with no internal FIFO:
 * receive path from an internal frame source, transmit path to the
 * media side with optional CRC insertion, and per-port link clocks.
 * assumes all inputs synchronous to CORE_CLK; media-side frame source
 * is an internal byte stream with its own start, end and error flags.
 */
`timescale 1ns/1ps
`include "mpcs_regs.svh"

// What this block does
// - per-port receive clock at 2.5 MHz; the 25/125 MHz speeds pass the core clock
// - per-port transmit clock at 2.5 MHz; the 25/125 MHz speeds pass the core clock
// - receive valid only with valid fields
// - receive start marker with first byte
// - receive end marker with last byte
// - not ready: drop or truncate with error
// - receive error vector with final byte
// - error bits 4..0 map to 5..1
// - transmit error vector forwards frame errored
// - transmit ready when able to accept
// - low CRC control at end inserts CRC
module mpcs_client #(
    parameter int PORTS = 2
) (
    input  wire logic                      CORE_CLK,
    input  wire logic                      RST_B,
    input  wire logic [2*PORTS-1:0]        SPEED,
    output logic      [PORTS-1:0]          MAC_RX_CLK,
    output logic      [PORTS-1:0]          MAC_TX_CLK,
    // media-side receive source (one byte per cycle, no back-pressure)
    input  wire logic [PORTS-1:0]          MED_RX_VALID,
    input  wire logic [8*PORTS-1:0]        MED_RX_DATA,
    input  wire logic [PORTS-1:0]          MED_RX_SOP,
    input  wire logic [PORTS-1:0]          MED_RX_EOP,
    input  wire logic [6*PORTS-1:0]        MED_RX_ERR,
    // client receive stream
    output logic      [PORTS-1:0]          RX_VALID,
    output logic      [8*PORTS-1:0]        RX_DATA,
    output logic      [PORTS-1:0]          RX_SOP,
    output logic      [PORTS-1:0]          RX_EOP,
    output logic      [5*PORTS-1:0]        RX_ERROR,
    input  wire logic [PORTS-1:0]          RX_READY,
    // client transmit stream
    input  wire logic [PORTS-1:0]          TX_VALID,
    input  wire logic [8*PORTS-1:0]        TX_DATA,
    input  wire logic [PORTS-1:0]          TX_SOP,
    input  wire logic [PORTS-1:0]          TX_EOP,
    input  wire logic [5*PORTS-1:0]        TX_ERROR,
    input  wire logic [PORTS-1:0]          TX_CRC_FWD_B,
    output logic      [PORTS-1:0]          TX_READY,
    // media-side transmit sink
    output logic      [PORTS-1:0]          MED_TX_EN,
    output logic      [8*PORTS-1:0]        MED_TX_DATA,
    output logic      [PORTS-1:0]          MED_TX_ERR,
    input  wire logic [PORTS-1:0]          MED_TX_READY
);
    localparam int DW = `MPCS_DATA_W;
    localparam int EW = `MPCS_ERR_W;

    // ======================================================================
    // per-port logic: every stream is replicated by this loop
    genvar p;
    generate
        for (p = 0; p < PORTS; p++)
        begin : g_port
            typedef struct packed {
                logic [`MPCS_DIV_W-1:0] div;
                logic                   lclk;
                mpcs_pkg::mpcs_rxst_t   rxst;
                // two-entry receive buffer
                logic [1:0]             bv;
                logic [1:0][DW+EW+1:0]  bd;
                logic                   bwr;
                logic                   brd;
                mpcs_pkg::mpcs_txst_t   txst;
                logic [31:0]            crc;
                logic [1:0]             crc_idx;
                logic                   terr;
                logic                   men;
                logic [DW-1:0]          mdata;
                logic                   merr;
            } mpcs_port_t;

            mpcs_port_t st;
            mpcs_port_t next_st;
            mpcs_pkg::mpcs_speed_t spd;
            logic [DW-1:0] rdat;
            logic [EW-1:0] rerr;
            logic          push;
            logic          pop;
            logic          full;
            logic [DW+EW+1:0] head;
            logic          tx_take;
            logic          med_free;

            assign spd  = mpcs_pkg::mpcs_speed_t'(SPEED[2*p +: 2]);
            assign rdat = MED_RX_DATA[DW*p +: DW];
            // media error bits 5..1 land on vector bits 4..0
            assign rerr = MED_RX_ERR[6*p+1 +: EW];
            assign full = &st.bv;
            assign head = st.bd[st.brd];
            assign pop  = st.bv[st.brd] & RX_READY[p];
            assign med_free = ~st.men | MED_TX_READY[p];
            // stall the client while the CRC tail is being sent
            assign TX_READY[p] = med_free &
                (st.txst == mpcs_pkg::MPCS_TX_DATA);
            assign tx_take = TX_VALID[p] & TX_READY[p];

            // link clocks: full rate shown as the core clock gated level
            assign MAC_RX_CLK[p] = (spd == mpcs_pkg::MPCS_SPD_10) ?
                                   st.lclk : CORE_CLK;
            assign MAC_TX_CLK[p] = MAC_RX_CLK[p];

            // receive outputs straight from buffer flip-flops
            assign RX_VALID[p]        = st.bv[st.brd];
            assign RX_DATA[DW*p +: DW] = head[DW+EW+1:EW+2];
            assign RX_SOP[p]          = head[EW+1];
            assign RX_EOP[p]          = head[EW];
            assign RX_ERROR[EW*p +: EW] = head[EW-1:0];
            assign MED_TX_EN[p]       = st.men;
            assign MED_TX_DATA[DW*p +: DW] = st.mdata;
            assign MED_TX_ERR[p]      = st.merr;

            // next-state: divider, receive drop/truncate, transmit CRC
            always_comb
            begin
                logic [31:0] c;
                logic [DW-1:0] b;
                c = st.crc;
                b = '0;
                next_st = st;
                push = 1'b0;
                // 2.5 MHz strobe from core clock divider
                if (st.div == `MPCS_DIV_W'(`MPCS_DIV_10_HALF - 1))
                begin
                    next_st.div  = '0;
                    next_st.lclk = ~st.lclk;
                end
                else
                begin
                    next_st.div = st.div + `MPCS_DIV_W'(1);
                end
                if (pop)
                begin
                    next_st.bv[st.brd] = 1'b0;
                    next_st.brd = ~st.brd;
                end
                // receive: buffer full mid-frame truncates with error
                if (MED_RX_VALID[p])
                begin
                    unique case (st.rxst)
                        mpcs_pkg::MPCS_RX_IDLE,
                        mpcs_pkg::MPCS_RX_PASS:
                        begin
                            if (full && !pop)
                            begin
                                if (st.rxst == mpcs_pkg::MPCS_RX_PASS)
                                begin
                                    // mark last buffered byte as errored end
                                    next_st.bd[~st.bwr][EW] = 1'b1;
                                    next_st.bd[~st.bwr][0]  = 1'b1;
                                end
                                next_st.rxst = MED_RX_EOP[p] ?
                                    mpcs_pkg::MPCS_RX_IDLE :
                                    mpcs_pkg::MPCS_RX_DROP;
                            end
                            else if (MED_RX_SOP[p] ||
                                     st.rxst == mpcs_pkg::MPCS_RX_PASS)
                            begin
                                push = 1'b1;
                                next_st.bd[st.bwr] = {rdat, MED_RX_SOP[p],
                                    MED_RX_EOP[p],
                                    MED_RX_EOP[p] ? rerr : 5'h0_0};
                                next_st.bv[st.bwr] = 1'b1;
                                next_st.bwr = ~st.bwr;
                                next_st.rxst = MED_RX_EOP[p] ?
                                    mpcs_pkg::MPCS_RX_IDLE :
                                    mpcs_pkg::MPCS_RX_PASS;
                            end
                        end
                        mpcs_pkg::MPCS_RX_DROP:
                        begin
                            // rest of a truncated frame is discarded
                            if (MED_RX_EOP[p])
                                next_st.rxst = mpcs_pkg::MPCS_RX_IDLE;
                        end
                        default: next_st.rxst = mpcs_pkg::MPCS_RX_IDLE;
                    endcase
                end
                // transmit path
                if (med_free)
                begin
                    // error flag must not outlive its byte on the media
                    next_st.men  = 1'b0;
                    next_st.merr = 1'b0;
                end
                if (tx_take)
                begin
                    b = TX_DATA[DW*p +: DW];
                    if (TX_SOP[p])
                        c = `MPCS_CRC_INIT;
                    for (int k = 0; k < 8; k++)
                        c = (c >> 1) ^ (((c[0] ^ b[k])) ?
                            `MPCS_CRC_POLY : 32'h0000_0000);
                    next_st.crc   = c;
                    next_st.men   = 1'b1;
                    next_st.mdata = b;
                    next_st.terr  = |TX_ERROR[EW*p +: EW];
                    next_st.merr  = 1'b0;
                    if (TX_EOP[p])
                    begin
                        if (!TX_CRC_FWD_B[p])
                        begin
                            next_st.txst    = mpcs_pkg::MPCS_TX_CRC;
                            next_st.crc_idx = 2'd0;
                        end
                        else
                        begin
                            next_st.merr = |TX_ERROR[EW*p +: EW];
                        end
                    end
                end
                else if (st.txst == mpcs_pkg::MPCS_TX_CRC && med_free)
                begin
                    c = ~st.crc;
                    next_st.men   = 1'b1;
                    next_st.mdata = c[8*st.crc_idx +: 8];
                    next_st.merr  = (st.crc_idx == 2'd3) & st.terr;
                    next_st.crc_idx = st.crc_idx + 2'd1;
                    if (st.crc_idx == 2'd3)
                        next_st.txst = mpcs_pkg::MPCS_TX_DATA;
                end
            end

            // state register
            always_ff @(posedge CORE_CLK or negedge RST_B)
            begin
                if (!RST_B)
                    st <= '0;
                else
                    st <= next_st;
            end

            // stalled output stays valid and holds its word
            a_rx_hold: assert property (
                @(posedge CORE_CLK) disable iff (!RST_B)
                RX_VALID[p] && !RX_READY[p] |=>
                RX_VALID[p] && $stable(RX_DATA[DW*p +: DW]))
                else $error("receive word changed while stalled");
            // crc insertion: end byte taken, then four tail cycles
            sequence s_crc_req;
                tx_take && TX_EOP[p] && !TX_CRC_FWD_B[p];
            endsequence
            sequence s_crc_tail;
                !TX_READY[p] [*4];
            endsequence
            a_tx_stall: assert property (
                @(posedge CORE_CLK) disable iff (!RST_B)
                s_crc_req |=> s_crc_tail)
                else $error("transmit not stalled for CRC tail");
            a_tx_fwd: assert property (
                @(posedge CORE_CLK) disable iff (!RST_B)
                tx_take |=> MED_TX_EN[p] &&
                MED_TX_DATA[DW*p +: DW] == $past(TX_DATA[DW*p +: DW]))
                else $error("accepted byte not forwarded");
            a_rx_errpos: assert property (
                @(posedge CORE_CLK) disable iff (!RST_B)
                RX_VALID[p] && !RX_EOP[p] |-> RX_ERROR[EW*p +: EW] == 5'h0_0)
                else $error("error vector off the final byte");
            // an empty buffer shows a new frame's first byte next cycle
            a_rx_first: assert property (
                @(posedge CORE_CLK) disable iff (!RST_B)
                push && MED_RX_SOP[p] && st.bv == 2'b00 |=>
                RX_VALID[p] && RX_SOP[p] &&
                RX_DATA[DW*p +: DW] == $past(rdat))
                else $error("first byte not shown with start marker");
            // a media error flag never stands without its byte
            a_med_err: assert property (
                @(posedge CORE_CLK) disable iff (!RST_B)
                MED_TX_ERR[p] |-> MED_TX_EN[p])
                else $error("transmit error raised without a byte");
        end
    endgenerate
endmodule // mpcs_client

// >>> dv/mpcs_app_model.sv
/*
 * application-side model of one port's client streams.
 * assumes calls made just after a rising clk edge.
 */
`timescale 1ns/1ps
// ==========================================================================
// user application model
module mpcs_app_model (
    input  wire logic       clk,
    input  wire logic       rx_valid,
    input  wire logic [7:0] rx_data,
    input  wire logic       rx_sop,
    input  wire logic       rx_eop,
    input  wire logic [4:0] rx_error,
    output logic            rx_ready,
    output logic            tx_valid,
    output logic      [7:0] tx_data,
    output logic            tx_sop,
    output logic            tx_eop,
    output logic      [4:0] tx_error,
    output logic            tx_crc_fwd_b,
    input  wire logic       tx_ready
);
    logic [14:0] rxq[$];
    logic        tmo = 1'b0;
    // idle values; ready starts high so nothing is truncated by default
    initial
    begin
        {rx_ready, tx_valid, tx_data, tx_sop, tx_eop, tx_error} = 17'h1_0000;
        tx_crc_fwd_b = 1'b1;
    end
    // a byte counts only when valid and ready meet at an edge
    always @(posedge clk)
        if (rx_valid === 1'b1 && rx_ready)
            rxq.push_back({rx_error, rx_eop, rx_sop, rx_data});
    // one frame; every field held until the edge that accepts it
    task automatic send(input logic [7:0] b[$], input logic crc_b,
                        input logic [4:0] err);
        int n;
        for (int i = 0; i < b.size(); i++)
        begin
            tx_valid     <= 1'b1;
            tx_data      <= b[i];
            tx_sop       <= (i == 0);
            tx_eop       <= (i == b.size() - 1);
            tx_error     <= (i == b.size() - 1) ? err : 5'h00;
            tx_crc_fwd_b <= (i == b.size() - 1) ? crc_b : 1'b1;
            n = 0;
            do
            begin
                @(posedge clk);
                n++;
            end
            while (tx_ready !== 1'b1 && n < 200);
            if (n >= 200)
            begin
                // stuck handshake: give up so the run reaches its report
                tmo = 1'b1;
                break;
            end
        end
        // released data shows a different value, never the last byte
        tx_valid <= 1'b0;
        tx_data  <= ~tx_data;
    endtask
endmodule // mpcs_app_model

// >>> dv/test_mpcs_client.sv
/*
 * self-checking bench for one port of the client stream block.
 * assumes the application model drives the client side.
 */
`timescale 1ns/1ps
`include "mpcs_regs.svh"
// ==========================================================================
// bench top
module test_mpcs_client;
    logic       CORE_CLK = 1'b0, RST_B = 1'b0, MED_TX_READY = 1'b1;
    logic [1:0] SPEED = mpcs_pkg::MPCS_SPD_1000;
    logic       MED_RX_VALID = 1'b0, MED_RX_SOP = 1'b0, MED_RX_EOP = 1'b0;
    logic [7:0] MED_RX_DATA = 8'h00, RX_DATA, TX_DATA, MED_TX_DATA;
    logic [5:0] MED_RX_ERR = 6'h00;
    logic [4:0] RX_ERROR, TX_ERROR;
    logic       MAC_RX_CLK, MAC_TX_CLK, RX_VALID, RX_SOP, RX_EOP, RX_READY;
    logic       TX_VALID, TX_SOP, TX_EOP, TX_CRC_FWD_B, TX_READY;
    logic       MED_TX_EN, MED_TX_ERR, stall_on = 1'b0;
    logic [8:0] medq[$];
    int         bad_count = 0;
    int         num_checks = 0;
    always #25 CORE_CLK = ~CORE_CLK;
    // media sink: stalling toggles ready every cycle to force back-pressure
    always @(posedge CORE_CLK)
        MED_TX_READY <= stall_on ? ~MED_TX_READY : 1'b1;
    always @(posedge CORE_CLK)
        if (MED_TX_EN === 1'b1 && MED_TX_READY)
            medq.push_back({MED_TX_ERR, MED_TX_DATA});
    mpcs_client #(.PORTS(1)) dut_u (.CORE_CLK(CORE_CLK), .RST_B(RST_B),
        .SPEED(SPEED), .MAC_RX_CLK(MAC_RX_CLK), .MAC_TX_CLK(MAC_TX_CLK),
        .MED_RX_VALID(MED_RX_VALID), .MED_RX_DATA(MED_RX_DATA),
        .MED_RX_SOP(MED_RX_SOP), .MED_RX_EOP(MED_RX_EOP),
        .MED_RX_ERR(MED_RX_ERR), .RX_VALID(RX_VALID), .RX_DATA(RX_DATA),
        .RX_SOP(RX_SOP), .RX_EOP(RX_EOP), .RX_ERROR(RX_ERROR),
        .RX_READY(RX_READY), .TX_VALID(TX_VALID), .TX_DATA(TX_DATA),
        .TX_SOP(TX_SOP), .TX_EOP(TX_EOP), .TX_ERROR(TX_ERROR),
        .TX_CRC_FWD_B(TX_CRC_FWD_B), .TX_READY(TX_READY),
        .MED_TX_EN(MED_TX_EN), .MED_TX_DATA(MED_TX_DATA),
        .MED_TX_ERR(MED_TX_ERR), .MED_TX_READY(MED_TX_READY));
    mpcs_app_model app_u (.clk(CORE_CLK), .rx_valid(RX_VALID),
        .rx_data(RX_DATA), .rx_sop(RX_SOP), .rx_eop(RX_EOP),
        .rx_error(RX_ERROR), .rx_ready(RX_READY), .tx_valid(TX_VALID),
        .tx_data(TX_DATA), .tx_sop(TX_SOP), .tx_eop(TX_EOP),
        .tx_error(TX_ERROR), .tx_crc_fwd_b(TX_CRC_FWD_B),
        .tx_ready(TX_READY));
    // ======================================================================
    // compare, frame and crc helpers
    task automatic chk_word(input string what, input logic [14:0] e, g);
        num_checks++;
        if (g !== e)
        begin
            bad_count++;
            $display("mismatch %s expected %h seen %h", what, e, g);
        end
    endtask
    task automatic chk_num(input string what, input int e, g);
        chk_word(what, 15'(e), 15'(g));
    endtask
    // reflected crc, sent low byte first
    function automatic logic [31:0] fcs(input logic [7:0] b[$]);
        logic [31:0] c;
        c = `MPCS_CRC_INIT;
        foreach (b[i])
        begin
            c = c ^ 32'(b[i]);
            for (int k = 0; k < 8; k++)
                c = c[0] ? (c >> 1) ^ `MPCS_CRC_POLY : c >> 1;
        end
        return ~c;
    endfunction
    task automatic med_frame(input int len, input logic [7:0] base,
                             input logic [5:0] err);
        for (int i = 0; i < len; i++)
        begin
            MED_RX_VALID <= 1'b1;
            MED_RX_DATA  <= base + 8'(i);
            MED_RX_SOP   <= (i == 0);
            MED_RX_EOP   <= (i == len - 1);
            MED_RX_ERR   <= (i == len - 1) ? err : 6'h00;
            @(posedge CORE_CLK);
        end
        MED_RX_VALID <= 1'b0;
        MED_RX_DATA  <= ~MED_RX_DATA;
        repeat (4) @(posedge CORE_CLK);
    endtask
    // ======================================================================
    // scenarios
    task automatic rx_stall();
        app_u.rxq.delete();
        app_u.rx_ready <= 1'b0;
        med_frame(5, 8'h40, 6'h00);
        app_u.rx_ready <= 1'b1;
        repeat (4) @(posedge CORE_CLK);
        chk_num("rx trunc count", 2, app_u.rxq.size());
        chk_word("rx trunc first", 15'h0140, app_u.rxq[0]);
        chk_word("rx trunc last", 15'h0641, app_u.rxq[1]);
        $display("test rx_stall done");
    endtask
    task automatic rx_pass();
        app_u.rxq.delete();
        med_frame(4, 8'h10, 6'h2d);
        chk_num("rx count", 4, app_u.rxq.size());
        for (int i = 0; i < 4; i++)
            chk_word("rx byte", {(i == 3) ? 5'h16 : 5'h00, i == 3, i == 0,
                8'h10 + 8'(i)}, app_u.rxq[i]);
        $display("test rx_pass done");
    endtask
    task automatic tx_frame(input logic [7:0] d[$], input logic crc_b,
                            input logic [4:0] err, input logic [7:0] x[$]);
        medq.delete();
        app_u.send(d, crc_b, err);
        repeat (20) @(posedge CORE_CLK);
        chk_num("tx count", x.size(), medq.size());
        foreach (x[i])
            chk_word("tx byte", {6'h00, i == x.size() - 1 && err != 5'h00,
                x[i]}, {6'h00, medq[i]});
    endtask
    task automatic tx_crc();
        logic [7:0]  d[$];
        logic [31:0] c;
        logic [7:0]  x[$];
        d = {8'h01, 8'h02, 8'h03, 8'h04};
        c = fcs(d);
        x = {d, c[7:0], c[15:8], c[23:16], c[31:24]};
        tx_frame(d, 1'b0, 5'h04, x);
        $display("test tx_crc done");
    endtask
    task automatic tx_nocrc();
        logic [7:0]  d[$];
        logic [31:0] c;
        d = {8'ha5, 8'h5a, 8'h33};
        c = fcs(d);
        d = {d, c[7:0], c[15:8], c[23:16], c[31:24]};
        stall_on <= 1'b1;
        tx_frame(d, 1'b1, 5'h01, d);
        stall_on <= 1'b0;
        $display("test tx_nocrc done");
    endtask
    task automatic clk_div();
        logic r;
        logic t;
        int   nr;
        int   nt;
        SPEED <= mpcs_pkg::MPCS_SPD_10;
        repeat (8) @(posedge CORE_CLK);
        {nr, nt, r, t} = {64'h0, MAC_RX_CLK, MAC_TX_CLK};
        repeat (40)
        begin
            @(posedge CORE_CLK);
            nr += int'(MAC_RX_CLK !== r);
            nt += int'(MAC_TX_CLK !== t);
            {r, t} = {MAC_RX_CLK, MAC_TX_CLK};
        end
        chk_num("rx clk edges", 40 / `MPCS_DIV_10_HALF, nr);
        chk_num("tx clk edges", 40 / `MPCS_DIV_10_HALF, nt);
        $display("test clk_div done");
    endtask
    task automatic final_report();
        $display("checks %0d mismatches %0d", num_checks, bad_count);
        if (bad_count == 0 && num_checks > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    // main sequence; a stuck handshake in the model counts as a mismatch
    initial
    begin
        repeat (20) @(posedge CORE_CLK);
        RST_B <= 1'b1;
        @(posedge CORE_CLK);
        rx_stall();
        rx_pass();
        tx_crc();
        tx_nocrc();
        clk_div();
        if (app_u.tmo)
            bad_count++;
        final_report();
    end
endmodule // test_mpcs_client
